// file: ptm_pkg.sv
package ptm_pkg;
	// channel and store geometry
	localparam int NUM_CHAN = 3;
	localparam int NUM_WORK = 16;
	localparam int NUM_SLOTS = 32;
	// timing: one pass waits this long before the channels are looked at
	localparam int CLK_FREQ_HZ = 40_000_000;
	localparam int WAIT_TIME_US = 4000;
	localparam int TICK_CYCLES = WAIT_TIME_US * (CLK_FREQ_HZ / 1_000_000);
	// byte offsets on the register bus
	localparam logic [11:0] OFS_WORK_BASE = 12'h000;
	localparam logic [11:0] OFS_CTRL = 12'h040;
	localparam logic [11:0] OFS_STATUS = 12'h044;
	localparam logic [11:0] OFS_IRQ_FLAG = 12'h048;
	localparam logic [11:0] OFS_IRQ_MASK = 12'h04c;
	localparam logic [11:0] OFS_INSN_BASE = 12'h080;
	// work register roles
	localparam int CH_ENABLE_IDX [NUM_CHAN] = '{1, 6, 9};
	localparam int CH_COUNTER_IDX [NUM_CHAN] = '{2, 7, 10};
	localparam int CH_LIMIT_IDX [NUM_CHAN] = '{3, 8, 11};
	localparam int IDX_FIXED_ZERO = 0;
	localparam int IDX_STEP = 13;
	localparam int IDX_FIXED_ONES = 15;
	// interrupt bit of each channel in the low flag and mask bytes
	localparam int CH_IRQ_BIT [NUM_CHAN] = '{3, 4, 6};
	localparam logic [7:0] IRQ_FLAG_RESET = 8'h00;
	localparam logic [7:0] IRQ_MASK_RESET = 8'hff;
	// work register reset values, register 15 first
	localparam logic [NUM_WORK*16-1:0] WORK_RESET = {16'hffff, 16'h0000, 16'h0001, 16'hffff,
		16'h00ff, 16'h0000, 16'h0000, 16'h00ff, 16'h0000, 16'h0000, 16'hffe0, 16'hffe4,
		16'h0113, 16'h0000, 16'h0000, 16'h0000};
	// command store reset image, slot 31 first
	localparam logic [NUM_SLOTS*16-1:0] INSN_RESET = {16'h0000, 16'h0000, 16'h0000, 16'hf000,
		16'h8e51, 16'h7c02, 16'h7c00, 16'h4560, 16'h5460, 16'h7aa1, 16'h8040, 16'h7ab2,
		16'h7ad0, 16'h8073, 16'h79d2, 16'h4540, 16'h5440, 16'h7771, 16'h8040, 16'h7782,
		16'h77d0, 16'h8073, 16'h76d2, 16'h4530, 16'h5430, 16'h7221, 16'h8040, 16'h7232,
		16'h72d0, 16'h8073, 16'h71d2, 16'h9c21};
	// command slot reached by each step of the pass
	localparam logic [4:0] SLOT_WAIT = 5'h00;
	localparam logic [4:0] SLOT_CH_BASE [NUM_CHAN] = '{5'h01, 5'h09, 5'h11};
	localparam logic [4:0] SLOT_FINISH = 5'h1c;
	// control and status fields
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_STOP_BIT = 1;
	localparam int STAT_RUN_BIT = 0;
	localparam int STAT_SLOT_LSB = 8;
	localparam int STAT_CHAN_LSB = 16;
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// sequencer states and address regions
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CHAN} ptm_state_t;
	typedef enum logic [2:0] {RG_NONE, RG_WORK, RG_CTRL, RG_STATUS, RG_FLAG, RG_MASK, RG_INSN} ptm_region_t;
endpackage

// file: ptm_tick_timer.sv
`timescale 1ns/1ps
module ptm_tick_timer #(
	parameter int TICKS = ptm_pkg::TICK_CYCLES
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// control
	input wire logic run,
	output logic done
);
	localparam int CW = $clog2(TICKS + 1);
	localparam logic [CW-1:0] LAST = CW'(TICKS - 1);
	logic [CW-1:0] cnt_r; // cycles spent in the current wait
	// count only while the sequencer waits; dropping run restarts the wait
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r <= '0;
		end else if (run && cnt_r == LAST) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= run ? cnt_r + CW'(1) : '0;
		end
	end
	// end flagged in the last counted cycle; a registered flag would stretch every wait by one clock
	assign done = run && (cnt_r == LAST);
endmodule // ptm_tick_timer

// file: ptm_chan_eval.sv
`timescale 1ns/1ps
module ptm_chan_eval (
	// channel words
	input wire logic [15:0] enable_word,
	input wire logic [15:0] counter,
	input wire logic [15:0] limit,
	input wire logic [15:0] step,
	// results
	output logic active,
	output logic overflow,
	output logic [15:0] next_counter
);
	logic [15:0] sum; // counter after this tick's step
	// enabled only on an exact match with the on value
	assign active = (enable_word == step);
	assign sum = counter + step;
	// the limit itself counts as overflow, like a no-borrow compare
	assign overflow = active && (sum >= limit);
	assign next_counter = overflow ? 16'h0000 : sum;
endmodule // ptm_chan_eval

// file: ptm_monitor.sv
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module ptm_monitor #(
	parameter int TICK_CYCLES = ptm_pkg::TICK_CYCLES,
	parameter int ADDR_W = 12
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write address channel
	input wire logic awvalid,
	output logic awready,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	// write data channel
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// write response channel
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// read address channel
	input wire logic arvalid,
	output logic arready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	// read data channel
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// requests to the interrupt controller
	output logic irq,
	output logic chan1_overflow_request,
	output logic chan2_overflow_request,
	output logic chan3_overflow_request
);
	localparam int NC = ptm_pkg::NUM_CHAN;

	// map a byte address onto a register region
	function automatic ptm_pkg::ptm_region_t region(input logic [ADDR_W-1:0] a);
		logic [11:0] o;
		o = 12'(a);
		if (o[1:0] != 2'h0) begin
			region = ptm_pkg::RG_NONE;
		end else if (o < ptm_pkg::OFS_CTRL) begin
			region = ptm_pkg::RG_WORK;
		end else if (o == ptm_pkg::OFS_CTRL) begin
			region = ptm_pkg::RG_CTRL;
		end else if (o == ptm_pkg::OFS_STATUS) begin
			region = ptm_pkg::RG_STATUS;
		end else if (o == ptm_pkg::OFS_IRQ_FLAG) begin
			region = ptm_pkg::RG_FLAG;
		end else if (o == ptm_pkg::OFS_IRQ_MASK) begin
			region = ptm_pkg::RG_MASK;
		end else if (o >= ptm_pkg::OFS_INSN_BASE && o < 12'h100) begin
			region = ptm_pkg::RG_INSN;
		end else begin
			region = ptm_pkg::RG_NONE;
		end
	endfunction

	// merge the two low byte lanes of a write into a 16-bit word
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	// bus channel state
	logic awready_r;
	logic wready_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic arready_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	logic aw_hold_r; // write address captured, waiting for data
	logic w_hold_r; // write data captured, waiting for address
	logic [ADDR_W-1:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;

	// block state
	logic [15:0] work_r [ptm_pkg::NUM_WORK]; // working registers
	logic [15:0] insn_r [ptm_pkg::NUM_SLOTS]; // command store
	logic [7:0] irq_flag_r; // low flag byte, sticky
	logic [7:0] irq_mask_r; // low mask byte, one masks
	ptm_pkg::ptm_state_t state_r;
	ptm_pkg::ptm_state_t state_nxt;
	logic [1:0] ch_r; // channel under test
	logic [1:0] ch_nxt;
	logic [4:0] slot_r; // command slot being executed
	logic [4:0] slot_nxt;
	logic stop_req_r; // finish at end of this pass
	logic irq_r;
	logic [NC-1:0] req_r;

	// decode
	logic aw_take;
	logic w_take;
	logic ar_take;
	logic do_write;
	ptm_pkg::ptm_region_t wr_rg;
	ptm_pkg::ptm_region_t rd_rg;
	logic [3:0] wr_widx;
	logic [4:0] wr_iidx;
	logic [3:0] rd_widx;
	logic [4:0] rd_iidx;
	logic [31:0] rd_data;
	logic start_pulse;
	logic stop_pulse;
	logic flag_wr;
	logic mask_wr;
	logic tick_done;

	// channel evaluation
	logic [NC-1:0] ch_active;
	logic [NC-1:0] ch_ovf;
	logic [15:0] ch_next [NC];
	logic in_chan;
	logic seq_we; // sequencer writes a counter this cycle
	logic [3:0] seq_idx;
	logic [15:0] seq_val;
	logic [7:0] set_bits; // flag bits raised this cycle
	logic [7:0] flag_nxt;
	logic [7:0] mask_nxt;
	logic [7:0] pending;

	// handshakes
	assign aw_take = awvalid && awready_r;
	assign w_take = wvalid && wready_r;
	assign ar_take = arvalid && arready_r;
	assign do_write = aw_hold_r && w_hold_r && !bvalid_r;

	// address decode for both directions
	assign wr_rg = region(aw_addr_r);
	assign rd_rg = region(araddr);
	assign wr_widx = aw_addr_r[5:2];
	assign wr_iidx = aw_addr_r[6:2];
	assign rd_widx = araddr[5:2];
	assign rd_iidx = araddr[6:2];

	// control strobes; start and stop are write-only pulses
	assign start_pulse = do_write && wr_rg == ptm_pkg::RG_CTRL && w_strb_r[0]
		&& w_data_r[ptm_pkg::CTRL_START_BIT];
	assign stop_pulse = do_write && wr_rg == ptm_pkg::RG_CTRL && w_strb_r[0]
		&& w_data_r[ptm_pkg::CTRL_STOP_BIT];
	assign flag_wr = do_write && wr_rg == ptm_pkg::RG_FLAG && w_strb_r[0];
	assign mask_wr = do_write && wr_rg == ptm_pkg::RG_MASK && w_strb_r[0];

	// read selection; narrow registers sit in the low bits
	assign rd_data = (rd_rg == ptm_pkg::RG_WORK) ? {16'h0000, work_r[rd_widx]} :
		(rd_rg == ptm_pkg::RG_INSN) ? {16'h0000, insn_r[rd_iidx]} :
		(rd_rg == ptm_pkg::RG_STATUS) ? {14'h0000, ch_r, 3'h0, slot_r, 7'h00, state_r != ptm_pkg::ST_IDLE} :
		(rd_rg == ptm_pkg::RG_FLAG) ? {24'h000000, irq_flag_r} :
		(rd_rg == ptm_pkg::RG_MASK) ? {24'h000000, irq_mask_r} :
		32'h00000000;

	// write address, write data and response channels
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			aw_addr_r <= '0;
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= ptm_pkg::RESP_OKAY;
		end else begin
			// either channel may arrive first; each closes until the response
			if (aw_take) begin
				aw_addr_r <= awaddr;
				aw_hold_r <= 1'b1;
				awready_r <= 1'b0;
			end
			if (w_take) begin
				w_data_r <= wdata;
				w_strb_r <= wstrb;
				w_hold_r <= 1'b1;
				wready_r <= 1'b0;
			end
			if (do_write) begin
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= (wr_rg == ptm_pkg::RG_NONE) ? ptm_pkg::RESP_SLVERR : ptm_pkg::RESP_OKAY;
			end else if (bvalid_r && bready) begin
				// reopen only after the response, so one write is in flight
				bvalid_r <= 1'b0;
				awready_r <= 1'b1;
				wready_r <= 1'b1;
			end
		end
	end

	// read address and read data channels
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= ptm_pkg::RESP_OKAY;
		end else if (ar_take) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b1;
			rdata_r <= rd_data;
			rresp_r <= (rd_rg == ptm_pkg::RG_NONE) ? ptm_pkg::RESP_SLVERR : ptm_pkg::RESP_OKAY;
		end else if (rvalid_r && rready) begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
		end
	end

	// pass timer, running only in the wait step
	ptm_tick_timer #(
		.TICKS(TICK_CYCLES)
	) u_tick (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(state_r == ptm_pkg::ST_WAIT),
		.done(tick_done)
	);

	// one evaluator per channel
	for (genvar c = 0; c < NC; c++) begin : g_chan
		ptm_chan_eval u_eval (
			.enable_word(work_r[ptm_pkg::CH_ENABLE_IDX[c]]),
			.counter(work_r[ptm_pkg::CH_COUNTER_IDX[c]]),
			.limit(work_r[ptm_pkg::CH_LIMIT_IDX[c]]),
			.step(work_r[ptm_pkg::IDX_STEP]),
			.active(ch_active[c]),
			.overflow(ch_ovf[c]),
			.next_counter(ch_next[c])
		);
		// flag bit of this channel rises on its overflow step
		assign set_bits[ptm_pkg::CH_IRQ_BIT[c]] = in_chan && ch_r == 2'(c) && ch_ovf[c];
	end
	assign set_bits[2:0] = 3'h0;
	assign set_bits[5] = 1'b0;
	assign set_bits[7] = 1'b0;

	// counter update of the channel under test
	assign in_chan = (state_r == ptm_pkg::ST_CHAN);
	assign seq_we = in_chan && ch_active[ch_r];
	assign seq_idx = 4'(ptm_pkg::CH_COUNTER_IDX[ch_r]);
	assign seq_val = ch_next[ch_r];

	// flag: hardware set wins over a write-one clear in the same cycle
	assign flag_nxt = (irq_flag_r & ~(flag_wr ? w_data_r[7:0] : 8'h00)) | set_bits;
	// mask: an overflow unmasks its channel even against a software write
	assign mask_nxt = (mask_wr ? w_data_r[7:0] : irq_mask_r) & ~set_bits;
	assign pending = flag_nxt & ~mask_nxt; // unmasked flags as they stand after this edge

	// working registers; fixed words ignore writes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < ptm_pkg::NUM_WORK; i++) begin
				work_r[i] <= ptm_pkg::WORK_RESET[i*16 +: 16];
			end
		end else begin
			for (int i = 0; i < ptm_pkg::NUM_WORK; i++) begin
				// a software write beats the tick, so a clear is never undone
				if (do_write && wr_rg == ptm_pkg::RG_WORK && wr_widx == 4'(i)
					&& i != ptm_pkg::IDX_FIXED_ZERO && i != ptm_pkg::IDX_FIXED_ONES) begin
					work_r[i] <= merge16(work_r[i], w_data_r, w_strb_r);
				end else if (seq_we && seq_idx == 4'(i)) begin
					work_r[i] <= seq_val;
				end
			end
		end
	end

	// command store, kept as a readable and writable image
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < ptm_pkg::NUM_SLOTS; i++) begin
				insn_r[i] <= ptm_pkg::INSN_RESET[i*16 +: 16];
			end
		end else if (do_write && wr_rg == ptm_pkg::RG_INSN) begin
			insn_r[wr_iidx] <= merge16(insn_r[wr_iidx], w_data_r, w_strb_r);
		end
	end

	// interrupt bytes and registered outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_flag_r <= ptm_pkg::IRQ_FLAG_RESET;
			irq_mask_r <= ptm_pkg::IRQ_MASK_RESET;
			irq_r <= 1'b0;
			req_r <= '0;
		end else begin
			irq_flag_r <= flag_nxt;
			irq_mask_r <= mask_nxt;
			irq_r <= |pending;
			for (int c = 0; c < NC; c++) begin
				req_r[c] <= pending[ptm_pkg::CH_IRQ_BIT[c]];
			end
		end
	end

	// pass sequence: wait, then one channel per cycle, then loop
	always_comb begin
		state_nxt = state_r;
		ch_nxt = ch_r;
		slot_nxt = slot_r;
		case (state_r)
			ptm_pkg::ST_IDLE: begin
				// a trigger starts the program at its first slot
				if (start_pulse) begin
					state_nxt = ptm_pkg::ST_WAIT;
					slot_nxt = ptm_pkg::SLOT_WAIT;
				end
			end
			ptm_pkg::ST_WAIT: begin
				if (tick_done) begin
					state_nxt = ptm_pkg::ST_CHAN;
					ch_nxt = 2'h0;
					slot_nxt = ptm_pkg::SLOT_CH_BASE[0];
				end
			end
			ptm_pkg::ST_CHAN: begin
				if (ch_r == 2'(NC - 1)) begin
					// the pass closes back to the wait unless stopped
					ch_nxt = 2'h0;
					state_nxt = stop_req_r ? ptm_pkg::ST_IDLE : ptm_pkg::ST_WAIT;
					slot_nxt = stop_req_r ? ptm_pkg::SLOT_FINISH : ptm_pkg::SLOT_WAIT;
				end else begin
					ch_nxt = ch_r + 2'h1;
					slot_nxt = ptm_pkg::SLOT_CH_BASE[ch_r + 2'h1];
				end
			end
			default: begin
				state_nxt = ptm_pkg::ST_IDLE;
			end
		endcase
	end

	// sequencer registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= ptm_pkg::ST_IDLE;
			ch_r <= 2'h0;
			slot_r <= ptm_pkg::SLOT_WAIT;
			stop_req_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			ch_r <= ch_nxt;
			slot_r <= slot_nxt;
			// a stop is honoured only at a pass boundary, never mid-channel
			stop_req_r <= (state_nxt == ptm_pkg::ST_IDLE) ? 1'b0 : (stop_req_r || stop_pulse);
		end
	end

	// outputs straight from flip-flops
	assign awready = awready_r;
	assign wready = wready_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign arready = arready_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;
	assign irq = irq_r;
	assign chan1_overflow_request = req_r[0];
	assign chan2_overflow_request = req_r[1];
	assign chan3_overflow_request = req_r[2];
endmodule // ptm_monitor

// file: ptm_irq_ctrl.sv
`timescale 1ns/1ps
// stand-in for the interrupt controller: counts each new request edge per channel
module ptm_irq_ctrl (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// request lines from the monitor, channel one in bit 0
	input wire logic [2:0] req,
	// edge counts seen so far
	output logic [7:0] cnt1,
	output logic [7:0] cnt2,
	output logic [7:0] cnt3
);
	logic [2:0] req_r; // levels seen at the previous edge
	// a level request counts once, however long it stays up
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			req_r <= 3'h0;
			cnt1 <= 8'h00;
			cnt2 <= 8'h00;
			cnt3 <= 8'h00;
		end else begin
			req_r <= req;
			cnt1 <= cnt1 + 8'(req[0] & ~req_r[0]);
			cnt2 <= cnt2 + 8'(req[1] & ~req_r[1]);
			cnt3 <= cnt3 + 8'(req[2] & ~req_r[2]);
		end
	end
endmodule // ptm_irq_ctrl

// file: ptm_chk_monitor.sv
`timescale 1ns/1ps
// port-level checker for the monitor's bus answers and interrupt outputs
module ptm_chk_monitor (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// bus handshakes
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	// interrupt outputs
	input wire logic irq,
	input wire logic chan1_overflow_request,
	input wire logic chan2_overflow_request,
	input wire logic chan3_overflow_request
);
	// one domain, so clock and reset are given once
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// the summary line must follow the three channel requests exactly
	irq_summary_a: assert property (irq == (chan1_overflow_request | chan2_overflow_request | chan3_overflow_request))
		else $error("irq differs from channel requests");
	// write answered two cycles after address and data taken together
	write_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
		else $error("write response late or missing");
	// response must wait for the master
	bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	// read data follows the address by one cycle
	read_answer_a: assert property (arvalid && arready |=> rvalid)
		else $error("read data late");
	read_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
		else $error("read data changed before taken");
	// only one transfer of each kind in flight
	read_block_a: assert property (rvalid |-> !arready)
		else $error("read address accepted while data pending");
	write_block_a: assert property (bvalid |-> !awready && !wready)
		else $error("write accepted while response pending");
	resp_code_a: assert property (rvalid |-> rresp inside {2'h0, 2'h2})
		else $error("illegal read response code");
endmodule // ptm_chk_monitor
bind ptm_monitor ptm_chk_monitor u_chk (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
	.wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
	.arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .irq(irq),
	.chan1_overflow_request(chan1_overflow_request), .chan2_overflow_request(chan2_overflow_request),
	.chan3_overflow_request(chan3_overflow_request));

// file: ptm_monitor_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin error_cnt++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module ptm_monitor_tb;
	localparam int TK = 20; // short tick keeps a pass at 23 cycles
	// bus, request and bench state
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid, irq;
	logic [2:0] rq;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [1:0] bresp, rresp, r;
	logic [7:0] n1, n2, n3;
	int error_cnt, tests_run, cyc, w, lim;
	int lag; // cycles the master holds back bready or rready, so answers must stand
	// reference image of the work registers
	int m [16] = '{0, 0, 0, 'h113, 'hffe4, 'hffe0, 0, 0, 'hff, 0, 0, 'hff, 'hffff, 1, 0, 'hffff};
	ptm_monitor #(.TICK_CYCLES(TK), .ADDR_W(12)) dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
		.awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
		.wstrb(4'hf), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
		.araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.irq(irq), .chan1_overflow_request(rq[0]), .chan2_overflow_request(rq[1]), .chan3_overflow_request(rq[2]));
	ptm_irq_ctrl ic (.aclk(aclk), .aresetn(aresetn), .req(rq), .cnt1(n1), .cnt2(n2), .cnt3(n3));
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	// hang guard, well above the longest expected run
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			stop_test();
		end
	end
	task stop_test;
		if (error_cnt == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// one write; address and data released each at its own handshake
	task automatic wr(input logic [11:0] a, input int v);
		logic ad;
		logic dd;
		ad = 1'b0;
		dd = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= 32'(v);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= (lag == 0);
		while (!(ad && dd)) begin
			@(posedge aclk);
			if (!ad && awready === 1'b1) begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (!dd && wready === 1'b1) begin
				dd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		repeat (lag) @(posedge aclk);
		bready <= 1'b1;
		do @(posedge aclk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
		// the fixed words 0 and 15 ignore writes
		if (a < 12'h040 && a[1:0] == 2'h0 && a != 12'h000 && a != 12'h03c) m[a[5:2]] = v & 'hffff;
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= (lag == 0);
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		repeat (lag) @(posedge aclk);
		rready <= 1'b1;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	// read a work word and compare with the image
	task automatic chkw(input int i);
		rd(12'(4 * i));
		`CHK(d, 32'(m[i]))
	endtask
	// wait for a channel request, bounded
	task automatic wq(input int b);
		w = 0;
		do begin
			@(posedge aclk);
			w++;
		end while (rq[b] !== 1'b1 && w < 2000);
	endtask
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, aresetn} = 6'h00;
		awaddr = 12'h000;
		araddr = 12'h000;
		wdata = 32'h0;
		void'($urandom(52));
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		`CHK({irq, rq}, 4'h0)
		for (int i = 0; i < 16; i++) chkw(i);
		rd(12'h048);
		`CHK(d, 32'h0)
		rd(12'h04c);
		`CHK(d, 32'hff)
		// unmapped place answers with an error and zero
		rd(12'h050);
		`CHK({d, r}, {32'h0, ptm_pkg::RESP_SLVERR})
		wr(12'h050, 1);
		`CHK(r, ptm_pkg::RESP_SLVERR)
		wr(12'h000, 'h1234);
		`CHK(r, ptm_pkg::RESP_OKAY)
		chkw(0);
		// command store holds its image and takes writes
		rd(12'h080);
		`CHK(d, {16'h0000, ptm_pkg::INSN_RESET[15:0]})
		wr(12'h0fc, 'h5a5a);
		rd(12'h0fc);
		`CHK(d, 32'h00005a5a)
		wr(12'h030, $urandom);
		chkw(12);
		// channel one overflow after a random limit; channel three holds a non-on value
		lim = 2 + $urandom % 4;
		wr(12'h00c, lim);
		wr(12'h024, 2);
		wr(12'h004, 1);
		wr(12'h040, 1);
		wq(0);
		`CHK((w + 11) / (TK + 3), lim)
		wr(12'h004, 0);
		chkw(2);
		chkw(10);
		`CHK(n1, 8'h01)
		// slow master from here: answers must wait for their ready
		lag = 1 + $urandom % 3;
		rd(12'h048);
		`CHK(d, 32'h08)
		rd(12'h04c);
		`CHK(d, 32'hf7)
		`CHK(irq, 1'b1)
		// mask, unmask, then clear the sticky flag
		wr(12'h04c, 'hff);
		`CHK(irq, 1'b0)
		wr(12'h04c, 'hf7);
		`CHK(irq, 1'b1)
		wr(12'h048, 'h08);
		`CHK({irq, rq}, 4'h0)
		lag = 0;
		// channel two kept alive by software clearing its counter every few cycles
		wr(12'h020, 3);
		wr(12'h018, 1);
		repeat (12) begin
			wr(12'h01c, 0);
			repeat (4) @(posedge aclk);
		end
		`CHK(n2, 8'h00)
		wq(1);
		// the controller counts the new level one clock after it appears
		@(posedge aclk);
		`CHK(n2, 8'h01)
		// channel three with the on value now
		wr(12'h02c, 1);
		wr(12'h024, 1);
		wq(2);
		rd(12'h048);
		`CHK(d, 32'h50)
		`CHK(n3, 8'h01)
		// stop ends the run at the pass boundary
		wr(12'h040, 2);
		repeat (40) @(posedge aclk);
		rd(12'h044);
		`CHK({d[12:8], d[0]}, 6'h38)
		stop_test();
	end
endmodule // ptm_monitor_tb
